// *** verilog/utsc_pkg.sv ***
`default_nettype none
package utsc_pkg;

   // Clock and bus timing
   localparam int CLK_MHZ        = 250;
   localparam int IDLE_TIME_MS   = 3;
   localparam int RESUME_TIME_MS = 20;
   localparam int IDLE_CYCLES    = IDLE_TIME_MS * 1000 * CLK_MHZ;
   localparam int RESUME_CYCLES  = RESUME_TIME_MS * 1000 * CLK_MHZ;
   localparam int CNT_W          = 23;

   // Geometry
   localparam int NUM_EP = 7;
   localparam int AW     = 6;
   localparam int DW     = 8;
   localparam int NFLAG  = 4;

   // Register offsets
   localparam logic [5:0] A_FLAGS       = 6'h00;
   localparam logic [5:0] A_CLEAR       = 6'h01;
   localparam logic [5:0] A_ENABLE      = 6'h02;
   localparam logic [5:0] A_LAST        = 6'h03;
   localparam logic [5:0] A_MODCTL      = 6'h04;
   localparam logic [5:0] A_CTLZERO     = 6'h05;
   localparam logic [5:0] A_ENDPOINT_CONTROL_BASE  = 6'h08;
   localparam logic [5:0] A_BDCTL_BASE  = 6'h10;
   localparam logic [5:0] A_BDCNT_BASE  = 6'h18;

   // Interrupt flag / enable / clear bit positions
   localparam int F_DONE   = 0;
   localparam int F_STALL  = 1;
   localparam int F_IDLE   = 2;
   localparam int F_RESUME = 3;

   // module_control bits
   localparam int MC_HOLD = 0;
   localparam int MC_WAKE = 1;
   // usb_control_zero bits
   localparam int CZ_LPEN   = 0;
   localparam int CZ_LPFLAG = 7;
   // endpoint_control bits
   localparam int EP_HSHK = 0;
   localparam int EP_HALT = 1;
   // descriptor control bits
   localparam int BD_HALT   = 2;
   localparam int BD_TOGGLE = 6;
   localparam int BD_OWN    = 7;
   // last-transaction information fields
   localparam int LT_EP_LSB = 4;
   localparam int LT_TX     = 3;
   localparam int LT_SETUP  = 2;

   typedef enum logic [1:0] {
      UTSC_TK_OUT   = 2'h0,
      UTSC_TK_IN    = 2'h1,
      UTSC_TK_SETUP = 2'h2
   } utsc_token_t;

   typedef enum logic [1:0] {
      UTSC_HS_NONE  = 2'h0,
      UTSC_HS_ACK   = 2'h1,
      UTSC_HS_NAK   = 2'h2,
      UTSC_HS_STALL = 2'h3
   } utsc_hs_t;

   typedef enum logic [1:0] {
      UTSC_PH_WAIT = 2'b01,
      UTSC_PH_DATA = 2'b10
   } utsc_phase_t;

   // One decoded transaction from the packet layer
   typedef struct packed {
      logic        valid;
      utsc_token_t kind;
      logic [3:0]  ep;
      logic        data1;
      logic [6:0]  count;
      logic        host_ack;
   } utsc_txn_t;

   // Engine answer for that transaction
   typedef struct packed {
      logic     valid;
      utsc_hs_t hs;
      logic     data1;
   } utsc_resp_t;

   typedef struct packed {
      logic        valid;
      logic [5:0]  addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } utsc_reg_req_t;

endpackage
`default_nettype wire

// *** verilog/utsc_ctrl.sv ***
`default_nettype none
module utsc_ctrl #(
   parameter int IDLE_CYCLES   = utsc_pkg::IDLE_CYCLES,
   parameter int RESUME_CYCLES = utsc_pkg::RESUME_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire utsc_pkg::utsc_reg_req_t reg_req,
   output logic [utsc_pkg::DW-1:0]     reg_rdata,
   input  wire utsc_pkg::utsc_txn_t    txn,
   output utsc_pkg::utsc_resp_t        resp,
   input  wire logic                   bus_activity,
   input  wire logic                   line_k,
   input  wire logic                   deep_stop_mode,
   output logic                        token_hold,
   output logic                        resume_drive,
   output logic                        usb_irq,
   output logic                        async_wake
);

   typedef struct packed {
      logic [utsc_pkg::NFLAG-1:0]             flags;
      logic [utsc_pkg::NFLAG-1:0]             enables;
      logic [7:0]                             last;
      logic                                   hold;
      logic                                   wake;
      logic                                   lp_en;
      logic                                   lp_flag;
      logic [utsc_pkg::NUM_EP-1:0][7:0]       ep_ctl;
      logic [utsc_pkg::NUM_EP-1:0][7:0]       bd_ctl;
      logic [utsc_pkg::NUM_EP-1:0][7:0]       bd_cnt;
      utsc_pkg::utsc_phase_t                  phase;
      logic                                   dir_valid;
      logic                                   dir_tx;
      logic [utsc_pkg::CNT_W-1:0]             idle_cnt;
      logic [utsc_pkg::CNT_W-1:0]             k_cnt;
      logic [7:0]                             rdata;
      utsc_pkg::utsc_resp_t                   resp;
   } utsc_state_t;

   utsc_state_t s;
   utsc_state_t next_s;

   logic [utsc_pkg::NFLAG-1:0] clr;
   logic [utsc_pkg::NFLAG-1:0] set;
   logic [2:0]                 ep;
   logic                       in_range;
   logic                       hshk;
   logic                       halted;
   logic                       owned;
   logic                       is_tx;
   logic                       is_setup;
   logic                       status_now;
   logic                       expect1;
   logic                       seq_ok;
   logic                       complete;

   localparam logic [utsc_pkg::CNT_W-1:0] IDLE_LIM = utsc_pkg::CNT_W'(IDLE_CYCLES);
   localparam logic [utsc_pkg::CNT_W-1:0] K_LIM    = utsc_pkg::CNT_W'(RESUME_CYCLES - 1);

   always_comb begin
      next_s     = s;
      next_s.resp  = '0;
      next_s.rdata = '0;
      clr        = '0;
      set        = '0;
      ep         = txn.ep[2:0];
      in_range   = (txn.ep < 4'(utsc_pkg::NUM_EP));
      hshk       = s.ep_ctl[ep][utsc_pkg::EP_HSHK];
      halted     = s.ep_ctl[ep][utsc_pkg::EP_HALT] | s.bd_ctl[ep][utsc_pkg::BD_HALT];
      owned      = s.bd_ctl[ep][utsc_pkg::BD_OWN];
      is_tx      = (txn.kind == utsc_pkg::UTSC_TK_IN);
      is_setup   = (txn.kind == utsc_pkg::UTSC_TK_SETUP);
      status_now = (ep == 3'h0) && (s.phase == utsc_pkg::UTSC_PH_DATA)
                   && s.dir_valid && (is_tx != s.dir_tx);
      // SETUP is always DATA0; status stage always DATA1
      if (is_setup) begin
         expect1 = 1'b0;
      end else if (status_now) begin
         expect1 = 1'b1;
      end else begin
         expect1 = s.bd_ctl[ep][utsc_pkg::BD_TOGGLE];
      end
      seq_ok   = !hshk || is_tx || (txn.data1 == expect1);
      complete = 1'b0;

      // Register reads: data stands in the following cycle only
      if (reg_req.rd) begin
         case (reg_req.addr)
            utsc_pkg::A_FLAGS:   next_s.rdata = {4'h0, s.flags};
            utsc_pkg::A_ENABLE:  next_s.rdata = {4'h0, s.enables};
            utsc_pkg::A_LAST:    next_s.rdata = s.last;
            utsc_pkg::A_MODCTL:  next_s.rdata = {6'h00, s.wake, s.hold};
            utsc_pkg::A_CTLZERO: next_s.rdata = {s.lp_flag, 6'h00, s.lp_en};
            default: begin
               for (int i = 0; i < utsc_pkg::NUM_EP; i++) begin
                  if (reg_req.addr == utsc_pkg::A_ENDPOINT_CONTROL_BASE + 6'(i)) begin
                     next_s.rdata = s.ep_ctl[i];
                  end
                  if (reg_req.addr == utsc_pkg::A_BDCTL_BASE + 6'(i)) begin
                     next_s.rdata = s.bd_ctl[i];
                  end
                  if (reg_req.addr == utsc_pkg::A_BDCNT_BASE + 6'(i)) begin
                     next_s.rdata = s.bd_cnt[i];
                  end
               end
            end
         endcase
      end

      // Register writes; hardware events below take precedence
      if (reg_req.wr) begin
         case (reg_req.addr)
            utsc_pkg::A_CLEAR:  clr = reg_req.wdata[utsc_pkg::NFLAG-1:0];
            utsc_pkg::A_ENABLE: next_s.enables = reg_req.wdata[utsc_pkg::NFLAG-1:0];
            utsc_pkg::A_MODCTL: begin
               next_s.hold = reg_req.wdata[utsc_pkg::MC_HOLD];
               next_s.wake = reg_req.wdata[utsc_pkg::MC_WAKE];
            end
            utsc_pkg::A_CTLZERO: next_s.lp_en = reg_req.wdata[utsc_pkg::CZ_LPEN];
            default: begin
               for (int i = 0; i < utsc_pkg::NUM_EP; i++) begin
                  if (reg_req.addr == utsc_pkg::A_ENDPOINT_CONTROL_BASE + 6'(i)) begin
                     next_s.ep_ctl[i] = reg_req.wdata;
                  end
                  if (reg_req.addr == utsc_pkg::A_BDCTL_BASE + 6'(i)) begin
                     next_s.bd_ctl[i] = reg_req.wdata;
                  end
                  if (reg_req.addr == utsc_pkg::A_BDCNT_BASE + 6'(i)) begin
                     next_s.bd_cnt[i] = reg_req.wdata;
                  end
               end
            end
         endcase
      end

      // Transaction engine
      if (txn.valid && in_range) begin
         next_s.resp.valid = 1'b1;
         if (halted) begin
            if (hshk) begin
               next_s.resp.hs = utsc_pkg::UTSC_HS_STALL;
               set[utsc_pkg::F_STALL] = 1'b1;
            end
         end else if ((s.hold && !is_setup) || !owned) begin
            if (hshk) begin
               next_s.resp.hs = utsc_pkg::UTSC_HS_NAK;
            end
         end else begin
            // Isochronous: no handshake, DATA0 on send
            next_s.resp.hs    = hshk ? utsc_pkg::UTSC_HS_ACK : utsc_pkg::UTSC_HS_NONE;
            next_s.resp.data1 = hshk & is_tx & expect1;
            complete = seq_ok && (!is_tx || !hshk || txn.host_ack);
         end
      end

      if (complete) begin
         set[utsc_pkg::F_DONE] = 1'b1;
         next_s.last = {1'b0, ep, is_tx, is_setup, 2'h0};
         next_s.bd_ctl[ep][utsc_pkg::BD_OWN] = 1'b0;
         if (!is_tx) begin
            next_s.bd_cnt[ep] = {1'b0, txn.count};
         end
         if (hshk) begin
            next_s.bd_ctl[ep][utsc_pkg::BD_TOGGLE] = ~expect1;
         end
         if (is_setup) begin
            next_s.hold      = 1'b1;
            next_s.phase     = utsc_pkg::UTSC_PH_DATA;
            next_s.dir_valid = 1'b0;
            next_s.bd_ctl[ep][utsc_pkg::BD_TOGGLE] = 1'b1;
         end else if (ep == 3'h0) begin
            if (status_now) begin
               next_s.phase = utsc_pkg::UTSC_PH_WAIT;
            end else if (!s.dir_valid) begin
               next_s.dir_valid = 1'b1;
               next_s.dir_tx    = is_tx;
            end
         end
      end

      // Idle-suspend detection: strictly more than the idle time
      if (bus_activity) begin
         next_s.idle_cnt = '0;
      end else if (s.idle_cnt < IDLE_LIM) begin
         next_s.idle_cnt = s.idle_cnt + 1'b1;
      end else if (s.idle_cnt == IDLE_LIM) begin
         next_s.idle_cnt = s.idle_cnt + 1'b1;
         set[utsc_pkg::F_IDLE] = 1'b1;
      end

      // Host resume: K state held for the full resume time
      if (!line_k) begin
         next_s.k_cnt = '0;
      end else if (s.k_cnt < K_LIM) begin
         next_s.k_cnt = s.k_cnt + 1'b1;
      end else if (s.k_cnt == K_LIM) begin
         next_s.k_cnt = s.k_cnt + 1'b1;
         set[utsc_pkg::F_RESUME] = 1'b1;
      end

      // Set wins over a clear in the same cycle
      next_s.flags = (s.flags & ~clr) | set;

      // Clearing the enable also clears the low-power flag
      next_s.lp_flag = next_s.lp_en & (s.lp_flag | (deep_stop_mode & line_k));
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s       <= '0;
         s.phase <= utsc_pkg::UTSC_PH_WAIT;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata    = s.rdata;
   assign resp         = s.resp;
   assign token_hold   = s.hold;
   assign resume_drive = s.wake;
   // Normal interrupt only while running; the wake path shares the line before the flag registers
   assign usb_irq      = ((|(s.flags & s.enables)) & ~deep_stop_mode)
                         | s.lp_flag | async_wake;
   // Clockless wake path for a stopped clock
   assign async_wake   = s.lp_en & deep_stop_mode & line_k;

endmodule
`default_nettype wire

// *** tb/utsc_ctrl_sva.sv ***
`default_nettype none
module utsc_ctrl_sva #(
   parameter int IDLE_CYCLES   = utsc_pkg::IDLE_CYCLES,
   parameter int RESUME_CYCLES = utsc_pkg::RESUME_CYCLES
) (
   input wire logic                    sys_clk,
   input wire logic                    sys_rst,
   input wire utsc_pkg::utsc_reg_req_t reg_req,
   input wire logic [utsc_pkg::DW-1:0] reg_rdata,
   input wire utsc_pkg::utsc_txn_t     txn,
   input wire utsc_pkg::utsc_resp_t    resp,
   input wire logic                    bus_activity,
   input wire logic                    line_k,
   input wire logic                    deep_stop_mode,
   input wire logic                    token_hold,
   input wire logic                    resume_drive,
   input wire logic                    usb_irq,
   input wire logic                    async_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] hshk;
   logic [6:0] halt;
   logic [3:0] ep_q;
   logic       setup_q;
   logic       modwr;
   assign modwr = reg_req.wr && reg_req.addr == utsc_pkg::A_MODCTL;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Shadow of handshake and halt bits, written through endpoint_control
   always_ff @(posedge sys_clk) begin
      ep_q <= txn.ep;
      setup_q <= txn.kind == utsc_pkg::UTSC_TK_SETUP && !txn.data1;
      if (sys_rst) begin
         hshk <= '0;
         halt <= '0;
      end else if (reg_req.wr && reg_req.addr[5:3] == 3'h1 && reg_req.addr[2:0] != 3'h7) begin
         hshk[reg_req.addr[2:0]] <= reg_req.wdata[utsc_pkg::EP_HSHK];
         halt[reg_req.addr[2:0]] <= reg_req.wdata[utsc_pkg::EP_HALT];
      end
   end
   sequence s_take;
      txn.valid && txn.ep < 4'h7;
   endsequence
   sequence s_setup_ack;
      resp.valid && setup_q && resp.hs == utsc_pkg::UTSC_HS_ACK;
   endsequence
   a_resp_follow: assert property (s_take |=> resp.valid)
      else $error("no answer one cycle after a transaction");
   a_resp_cause: assert property (resp.valid |-> $past(txn.valid))
      else $error("answer without a transaction");
   a_setup_hold: assert property (s_setup_ack |-> token_hold)
      else $error("token hold not set after setup");
   a_hold_stays: assert property (token_hold && !modwr |=> token_hold)
      else $error("token hold dropped without a write");
   a_wake_drive: assert property ($past(modwr) |->
      resume_drive == $past(reg_req.wdata[utsc_pkg::MC_WAKE]))
      else $error("resume drive does not follow control bit");
   a_iso_quiet: assert property (resp.valid && !hshk[ep_q[2:0]] |->
      resp.hs == utsc_pkg::UTSC_HS_NONE)
      else $error("handshake sent on isochronous endpoint");
   a_halt_stall: assert property (resp.valid && hshk[ep_q[2:0]] && halt[ep_q[2:0]] |->
      resp.hs == utsc_pkg::UTSC_HS_STALL)
      else $error("halted endpoint not stalled");
   a_wake_cause: assert property (async_wake |-> deep_stop_mode && line_k)
      else $error("wake outside deep stop resume");
   a_wake_irq: assert property (async_wake |-> usb_irq)
      else $error("wake without interrupt");
endmodule
bind utsc_ctrl utsc_ctrl_sva #(
   .IDLE_CYCLES  (IDLE_CYCLES),
   .RESUME_CYCLES(RESUME_CYCLES)
) i_utsc_ctrl_sva (
   .sys_clk, .sys_rst, .reg_req, .reg_rdata, .txn, .resp, .bus_activity, .line_k,
   .deep_stop_mode, .token_hold, .resume_drive, .usb_irq, .async_wake
);
`default_nettype wire

// *** tb/utsc_host_model.sv ***
`default_nettype none
module utsc_host_model (
   input  wire logic           sys_clk,
   output utsc_pkg::utsc_txn_t txn,
   output logic                bus_activity,
   output logic                line_k
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      txn = '0;
      bus_activity = 1'b0;
      line_k = 1'b0;
   end
   // One transaction pulse; released fields are scrambled so stale data never matches
   task automatic send(input logic [1:0] k, input logic [3:0] ep, input logic d1,
                       input logic [6:0] c, input logic ack);
      @(posedge sys_clk);
      txn <= {1'b1, k, ep, d1, c, ack};
      bus_activity <= 1'b1;
      @(posedge sys_clk);
      txn <= {1'b0, ~txn[14:0]};
      bus_activity <= 1'b0;
   endtask
   // Host resume signalling as a held K level
   task automatic set_k(input logic v);
      @(posedge sys_clk);
      line_k <= v;
   endtask
endmodule
`default_nettype wire

// *** tb/test_usb_device_transaction_suspend_ctrl.sv ***
`default_nettype none
module test_usb_device_transaction_suspend_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IDLE_N = 20;
   localparam int RES_N  = 10;
   logic                    sys_clk        = 1'b0;
   logic                    sys_rst        = 1'b1;
   logic                    deep_stop_mode = 1'b0;
   utsc_pkg::utsc_reg_req_t reg_req        = '0;
   utsc_pkg::utsc_txn_t     txn;
   utsc_pkg::utsc_resp_t    resp;
   logic [7:0]              reg_rdata;
   logic                    bus_activity, line_k, token_hold, resume_drive, usb_irq, async_wake;
   int                      failures       = 0;
   int                      check_count    = 0;
   always #2 sys_clk = ~sys_clk;
   utsc_ctrl #(.IDLE_CYCLES(IDLE_N), .RESUME_CYCLES(RES_N)) i_utsc_ctrl (
      .sys_clk, .sys_rst, .reg_req, .reg_rdata, .txn, .resp, .bus_activity, .line_k,
      .deep_stop_mode, .token_hold, .resume_drive, .usb_irq, .async_wake);
   utsc_host_model i_utsc_host_model (.sys_clk, .txn, .bus_activity, .line_k);
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{1'b1, a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e, string n);
      @(posedge sys_clk);
      reg_req <= '{1'b1, a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      reg_req <= '0;
      #1 chk(n, reg_rdata & m, e);
   endtask
   // Answer valid, handshake, and data toggle where IN data really goes out
   task automatic xact(input logic [1:0] k, input logic [3:0] ep, input logic d1,
                       input logic [6:0] c, input logic [1:0] hs);
      logic dm;
      dm = k == utsc_pkg::UTSC_TK_IN && !hs[1];
      i_utsc_host_model.send(k, ep, d1, c, 1'b1);
      #1 chk("answer", {4'h0, resp.valid, resp.data1 & dm, resp.hs}, {4'h0, 1'b1, d1 & dm, hs});
   endtask
   task automatic t_reset();
      logic [5:0] a[5] = '{6'h00, 6'h02, 6'h04, 6'h05, 6'h3F};
      foreach (a[i]) rd(a[i], 8'hFB, 8'h00, "reset read");
      chk("irq", {7'h00, usb_irq}, 8'h00);
   endtask
   task automatic t_control();
      wr(utsc_pkg::A_ENDPOINT_CONTROL_BASE, 8'h01);
      wr(utsc_pkg::A_BDCTL_BASE, 8'h80);
      xact(utsc_pkg::UTSC_TK_SETUP, 4'h0, 1'b0, 7'h08, utsc_pkg::UTSC_HS_ACK);
      chk("hold", {7'h00, token_hold}, 8'h01);
      rd(utsc_pkg::A_FLAGS, 8'h01, 8'h01, "done");
      rd(utsc_pkg::A_LAST, 8'hF0, 8'h00, "ep0");
      rd(utsc_pkg::A_BDCNT_BASE, 8'hFF, 8'h08, "count");
      wr(utsc_pkg::A_BDCTL_BASE, 8'hC0);
      xact(utsc_pkg::UTSC_TK_IN, 4'h0, 1'b1, 7'h00, utsc_pkg::UTSC_HS_NAK);
      wr(utsc_pkg::A_MODCTL, 8'h00);
      xact(utsc_pkg::UTSC_TK_IN, 4'h0, 1'b1, 7'h00, utsc_pkg::UTSC_HS_ACK);
      wr(utsc_pkg::A_BDCTL_BASE, 8'h80);
      xact(utsc_pkg::UTSC_TK_OUT, 4'h0, 1'b1, 7'h00, utsc_pkg::UTSC_HS_ACK);
      rd(utsc_pkg::A_BDCNT_BASE, 8'hFF, 8'h00, "status count");
      wr(utsc_pkg::A_BDCTL_BASE, 8'h80);
      xact(utsc_pkg::UTSC_TK_SETUP, 4'h0, 1'b0, 7'h08, utsc_pkg::UTSC_HS_ACK);
      wr(utsc_pkg::A_MODCTL, 8'h00);
      wr(utsc_pkg::A_BDCTL_BASE, 8'hC0);
      // Zero-length status IN; a new address would be loaded only after it completes
      xact(utsc_pkg::UTSC_TK_IN, 4'h0, 1'b1, 7'h00, utsc_pkg::UTSC_HS_ACK);
      rd(utsc_pkg::A_LAST, 8'hFF, 8'h08, "status in");
   endtask
   task automatic t_clear();
      wr(utsc_pkg::A_FLAGS, 8'h01);
      wr(utsc_pkg::A_CLEAR, 8'h02);
      rd(utsc_pkg::A_FLAGS, 8'h01, 8'h01, "kept");
      wr(utsc_pkg::A_CLEAR, 8'h01);
      rd(utsc_pkg::A_FLAGS, 8'h01, 8'h00, "cleared");
   endtask
   task automatic t_endpoints();
      wr(6'h0A, 8'h01);
      wr(6'h12, 8'h80);
      xact(utsc_pkg::UTSC_TK_OUT, 4'h2, 1'b0, 7'h05, utsc_pkg::UTSC_HS_ACK);
      rd(utsc_pkg::A_LAST, 8'hF0, 8'h20, "ep2");
      rd(6'h1A, 8'hFF, 8'h05, "ep2 count");
      wr(6'h12, 8'hC0);
      xact(utsc_pkg::UTSC_TK_OUT, 4'h2, 1'b0, 7'h09, utsc_pkg::UTSC_HS_ACK);
      rd(6'h1A, 8'hFF, 8'h05, "ep2 resend");
      wr(6'h0B, 8'h03);
      wr(6'h13, 8'h80);
      xact(utsc_pkg::UTSC_TK_OUT, 4'h3, 1'b0, 7'h01, utsc_pkg::UTSC_HS_STALL);
      rd(utsc_pkg::A_FLAGS, 8'h02, 8'h02, "stall flag");
      wr(6'h0C, 8'h01);
      wr(6'h14, 8'h84);
      xact(utsc_pkg::UTSC_TK_IN, 4'h4, 1'b0, 7'h00, utsc_pkg::UTSC_HS_STALL);
      wr(6'h15, 8'h80);
      xact(utsc_pkg::UTSC_TK_OUT, 4'h5, 1'b1, 7'h03, utsc_pkg::UTSC_HS_NONE);
      rd(6'h1D, 8'hFF, 8'h03, "iso count");
      wr(6'h15, 8'hC0);
      xact(utsc_pkg::UTSC_TK_IN, 4'h5, 1'b0, 7'h00, utsc_pkg::UTSC_HS_NONE);
   endtask
   task automatic t_idle();
      int n;
      wr(utsc_pkg::A_CLEAR, 8'h04);
      wr(utsc_pkg::A_ENABLE, 8'h04);
      i_utsc_host_model.send(2'h0, 4'h7, 1'b0, 7'h00, 1'b0);
      for (n = 0; n < 60 && usb_irq !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("idle time", {7'h00, n >= IDLE_N + 1 && n <= IDLE_N + 3}, 8'h01);
      if (n == 60) report_and_stop();
      wr(utsc_pkg::A_ENABLE, 8'h00);
      #1 chk("masked", {7'h00, usb_irq}, 8'h00);
      wr(utsc_pkg::A_CLEAR, 8'h04);
      rd(utsc_pkg::A_FLAGS, 8'h04, 8'h00, "idle clear");
   endtask
   task automatic t_resume();
      wr(utsc_pkg::A_ENABLE, 8'h08);
      i_utsc_host_model.set_k(1'b1);
      repeat (RES_N - 2) @(posedge sys_clk);
      #1 chk("early", {7'h00, usb_irq}, 8'h00);
      repeat (4) @(posedge sys_clk);
      #1 chk("resume irq", {7'h00, usb_irq}, 8'h01);
      @(posedge sys_clk);
      deep_stop_mode <= 1'b1;
      #1 chk("stopped", {6'h00, usb_irq, async_wake}, 8'h00);
      i_utsc_host_model.set_k(1'b0);
      wr(utsc_pkg::A_CLEAR, 8'h08);
      wr(utsc_pkg::A_ENABLE, 8'h00);
      deep_stop_mode <= 1'b0;
   endtask
   task automatic t_lowpower();
      wr(utsc_pkg::A_CTLZERO, 8'h01);
      deep_stop_mode <= 1'b1;
      i_utsc_host_model.set_k(1'b1);
      #1 chk("wake", {6'h00, usb_irq, async_wake}, 8'h03);
      i_utsc_host_model.set_k(1'b0);
      rd(utsc_pkg::A_CTLZERO, 8'h80, 8'h80, "lp flag");
      wr(utsc_pkg::A_CTLZERO, 8'h00);
      rd(utsc_pkg::A_CTLZERO, 8'hFF, 8'h00, "lp cleared");
      chk("lp irq", {7'h00, usb_irq}, 8'h00);
      deep_stop_mode <= 1'b0;
   endtask
   task automatic t_wakeup();
      wr(utsc_pkg::A_MODCTL, 8'h02);
      #1 chk("drive on", {7'h00, resume_drive}, 8'h01);
      wr(utsc_pkg::A_MODCTL, 8'h00);
      #1 chk("drive off", {7'h00, resume_drive}, 8'h00);
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_control();
      t_clear();
      t_endpoints();
      t_idle();
      t_resume();
      t_lowpower();
      t_wakeup();
      report_and_stop();
   end
endmodule
`default_nettype wire
